/* File: dv/bpsw_panel.sv */
// Purpose: Front panel power switch model for the sequencer bench.
// Assumes: The switch shorts the line to ground; a pull-up holds it high.
// Notes: Press length is in mclk cycles; contact bounce is not modelled.
`timescale 1ns/1ns
`default_nettype none

module bpsw_panel
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic press_go,
    input wire logic [7:0] press_len,
    output logic pwr_sw_b
);
    logic [7:0] cnt_reg;

    // ------------------------------------------------------------
    // Switch contact
    // ------------------------------------------------------------
    // A released contact floats, so the line shows the pull-up level.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_reg <= 8'h00;
        else if (press_go && cnt_reg == 8'h00)
            cnt_reg <= press_len;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
    assign pwr_sw_b = (cnt_reg == 8'h00);
endmodule : bpsw_panel
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the power state and wake sequencer.
// Assumes: Short hold and debounce counts so presses take few cycles.
// Notes: Temperatures idle hot, so any fan left running while asleep shows.
`timescale 1ns/1ns
`default_nettype none
`include "bpsw_regs.svh"

module tb;
    import bpsw_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam int unsigned DEB = 3;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic pwr_sw_b;
    logic sleep_to_disk = 1'b0;
    logic lanpme_en = 1'b0;
    logic [6:0] wake_src = 7'h00;
    logic chassis_closed = 1'b0;
    logic intrusion_clr = 1'b0;
    logic [4:0][7:0] volt_in = {5{8'h60}};
    logic [4:0][7:0] volt_hi = {5{8'h80}};
    logic [4:0][7:0] volt_lo = {5{8'h40}};
    logic [3:0][7:0] temp_in = {4{8'h50}};
    logic [1:0] power_state;
    logic core_pwr_en, wake_pulse, intrusion;
    logic [4:0] volt_fault;
    logic [2:0] fan_on;
    logic [2:0][7:0] fan_duty;
    logic press_go = 1'b0;
    logic [7:0] press_len = 8'h00;
    int n_errors = 0;
    int checks = 0;
    int n_wake = 0;

    bpsw_seq #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .pwr_sw_b(pwr_sw_b),
        .sleep_to_disk(sleep_to_disk), .lanpme_s5_en_in(lanpme_en),
        .wake_src(wake_src), .chassis_closed(chassis_closed),
        .intrusion_clr(intrusion_clr), .volt_in(volt_in),
        .volt_hi(volt_hi), .volt_lo(volt_lo), .temp_in(temp_in),
        .power_state(power_state), .core_pwr_en(core_pwr_en),
        .wake_pulse(wake_pulse), .intrusion(intrusion),
        .volt_fault(volt_fault), .fan_on(fan_on), .fan_duty(fan_duty));

    bpsw_panel i_panel (.mclk(mclk), .rst_b(rst_b), .press_go(press_go),
        .press_len(press_len), .pwr_sw_b(pwr_sw_b));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (wake_pulse === 1'b1)
            n_wake <= n_wake + 1;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                       input string msg);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // Waits out the press plus the debounce of the release.
    task automatic press(input logic [7:0] len);
        @(posedge mclk);
        press_go <= 1'b1;
        press_len <= len;
        @(posedge mclk);
        press_go <= 1'b0;
        step(int'(len) + DEB + 4);
    endtask : press

    // Outside working, core power and every fan must be off.
    task automatic chk_state(input logic [1:0] exp);
        chk(power_state, exp, "power state");
        chk(core_pwr_en, exp == 2'h0, "core power");
        if (exp != 2'h0)
            chk(fan_duty, 24'h0, "fan duty while asleep");
    endtask : chk_state

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_short();
        int w;
        chk_state(PS_S5); // reset in soft-off
        w = n_wake;
        press(8'h08);
        chk_state(PS_WORK); // off to working
        chk(n_wake - w, 1, "wake pulse count"); // single pulse
        sleep_to_disk <= 1'b0;
        press(8'h08);
        chk_state(PS_S3); // working to sleep
        press(8'h08);
        chk_state(PS_WORK); // sleep to working
        sleep_to_disk <= 1'b1;
        press(8'h08);
        chk_state(PS_S4); // working to disk sleep
        press(8'h08);
        chk_state(PS_WORK); // disk sleep to working
        press(8'h02);
        chk_state(PS_WORK); // press shorter than debounce ignored
    endtask : t_short

    task automatic t_long();
        press(8'(HOLD + 10));
        chk_state(PS_S5); // long press from working
        press(8'(HOLD + 10));
        chk_state(PS_S5); // long press in soft-off ignored
        press(8'h08);
        sleep_to_disk <= 1'b0;
        press(8'h08);
        press(8'(HOLD + 10));
        chk_state(PS_S5); // long press from sleep
        press(8'h08);
        chk_state(PS_WORK); // back to working
    endtask : t_long

    // Every source against every sleep state, both enable settings in S5.
    task automatic t_wake();
        logic ok;
        int w;
        for (int st = 1; st <= 3; st++)
            for (int b = 0; b < 7; b++)
                for (int en = 0; en <= (st == 3 ? 1 : 0); en++)
                begin
                    lanpme_en <= en[0];
                    sleep_to_disk <= (st == 2);
                    press(st == 3 ? 8'(HOLD + 10) : 8'h08);
                    chk_state(2'(st)); // entry
                    w = n_wake;
                    wake_src <= 7'h01 << b;
                    step(3);
                    wake_src <= 7'h00;
                    step(3);
                    ok = st == 1 || b == 2 || b == 3 || (b < 2 && (st == 2 || en == 1));
                    chk_state(ok ? 2'h0 : 2'(st));
                    chk(n_wake - w, ok, "wake pulse count");
                    if (!ok)
                        press(8'h08);
                end
    endtask : t_wake

    task automatic t_monitor();
        volt_in <= {8'h90, 8'h60, 8'h40, 8'h80, 8'h3F};
        temp_in <= {8'h20, 8'h50, 8'h20, 8'h30};
        step(3);
        chk(volt_fault, 5'h11, "voltage window");
        chk(fan_duty, {8'hFF, 8'hFF, 8'h40}, "fan duty");
        chk(fan_on, 3'h7, "fans on");
        temp_in <= {4{8'h28}};
        step(3);
        chk(fan_duty, 24'h0, "fan duty at floor");
        chassis_closed <= 1'b1;
        step(2);
        chk(intrusion, 1'b1, "intrusion set");
        intrusion_clr <= 1'b1;
        step(2);
        chk(intrusion, 1'b1, "intrusion held");
        chassis_closed <= 1'b0;
        step(2);
        chk(intrusion, 1'b0, "intrusion cleared");
        intrusion_clr <= 1'b0;
        temp_in <= {4{8'h50}};
        step(2);
    endtask : t_monitor

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        step(20000);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        step(2);
        t_short();
        t_long();
        t_wake();
        t_monitor();
        print_verdict();
    end
endmodule : tb
`default_nettype wire

/* File: logic/bpsw_pkg.sv */
// Purpose: Types for the board power state and wake control block.
// Assumes: Constants come from bpsw_regs.svh.
// Notes: All state of the sequencer lives in one packed struct.
`include "bpsw_regs.svh"

package bpsw_pkg;

    typedef enum logic [1:0] {PS_WORK, PS_S3, PS_S4, PS_S5} bpsw_pstate_t;

    typedef struct packed {
        bpsw_pstate_t pstate;
        logic sw_stable;
        logic [31:0] db_cnt;
        logic [31:0] hold_cnt;
        logic long_done;
        logic lanpme_s5_en;
        logic core_pwr_en;
        logic wake_pulse;
        logic intrusion;
        logic [`BPSW_NUM_VOLT-1:0] volt_fault;
        logic [`BPSW_NUM_FAN-1:0] fan_on;
        logic [`BPSW_NUM_FAN-1:0][7:0] fan_duty;
    } bpsw_state_t;

endpackage : bpsw_pkg

/* File: logic/bpsw_regs.svh */
// Purpose: Constants for the board power state and wake control block.
// Assumes: 100 MHz mclk.
// Notes: Times are given in their own unit; cycle counts derive from them.
`ifndef BPSW_REGS_SVH
`define BPSW_REGS_SVH

`define BPSW_CLK_MHZ 100
`define BPSW_HOLD_TIME_MS 4000
`define BPSW_DEBOUNCE_TIME_MS 10
`define BPSW_HOLD_CYCLES (`BPSW_HOLD_TIME_MS * 1000 * `BPSW_CLK_MHZ)
`define BPSW_DEBOUNCE_CYCLES (`BPSW_DEBOUNCE_TIME_MS * 1000 * `BPSW_CLK_MHZ)

`define BPSW_NUM_VOLT 5
`define BPSW_NUM_TEMP 4
`define BPSW_NUM_FAN 3
`define BPSW_NUM_WAKE 7

`define BPSW_WK_LAN 0
`define BPSW_WK_PME 1
`define BPSW_WK_PCIE 2
`define BPSW_WK_RTC 3
`define BPSW_WK_PS2 4
`define BPSW_WK_SERIAL 5
`define BPSW_WK_USB 6
`define BPSW_WK_DEEP_MASK 7'h0F
`define BPSW_WK_OFF_MASK 7'h0C
`define BPSW_WK_LANPME_MASK 7'h03

`define BPSW_FAN_T_ON 8'h28
`define BPSW_FAN_T_FULL 8'h50
`define BPSW_FAN_FULL 8'hFF
`define BPSW_FAN_SLOPE 3

`endif

/* File: logic/bpsw_seq.sv */
// Purpose: Board power state sequencer with wake, voltage, thermal and fan
//          control, and chassis intrusion reporting.
// Assumes: All inputs synchronous to mclk; power switch input active low.
// Notes: Long counts are parameters so simulation can shorten them.
//
// Overview of operation
// R01: Short press moves soft-off to working, working to sleep, sleep to working.
// R02: Press held past four seconds forces working or sleeping into soft-off.
// R03: Suspend-to-RAM wakes on every listed source.
// R04: Suspend-to-disk and soft-off ignore PS/2, serial and USB wake.
// R05: Network and PCI event wake from soft-off is off until enabled.
// R06: Core power is removed outside working; wake logic keeps watching.
// R07: Intrusion switch closed raises a sticky intrusion flag.
// R08: Each of five voltages is checked against its upper and lower limit.
// R09: Three fans get closed-loop speed and on/off from thermal readings.
// R10: Four temperature readings feed the fan control.
// R11: Fans run only while working and stop in every other state.
// R12: Press length is a debounced cycle count against the four-second mark.
`timescale 1ns/1ns
`default_nettype none
`include "bpsw_regs.svh"

module bpsw_seq
    import bpsw_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `BPSW_HOLD_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = `BPSW_DEBOUNCE_CYCLES
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pwr_sw_b,
    input wire logic sleep_to_disk,
    input wire logic lanpme_s5_en_in,
    input wire logic [`BPSW_NUM_WAKE-1:0] wake_src,
    input wire logic chassis_closed,
    input wire logic intrusion_clr,
    input wire logic [`BPSW_NUM_VOLT-1:0][7:0] volt_in,
    input wire logic [`BPSW_NUM_VOLT-1:0][7:0] volt_hi,
    input wire logic [`BPSW_NUM_VOLT-1:0][7:0] volt_lo,
    input wire logic [`BPSW_NUM_TEMP-1:0][7:0] temp_in,
    output logic [1:0] power_state,
    output logic core_pwr_en,
    output logic wake_pulse,
    output logic intrusion,
    output logic [`BPSW_NUM_VOLT-1:0] volt_fault,
    output logic [`BPSW_NUM_FAN-1:0] fan_on,
    output logic [`BPSW_NUM_FAN-1:0][7:0] fan_duty
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic wake_ok(
        input bpsw_pstate_t ps,
        input logic [`BPSW_NUM_WAKE-1:0] src,
        input logic s5_en
    );
        logic [`BPSW_NUM_WAKE-1:0] mask;
        mask = '0;
        unique case (ps)
            PS_WORK: mask = '0;
            PS_S3: mask = '1;
            PS_S4: mask = `BPSW_WK_DEEP_MASK;
            PS_S5: mask = s5_en ? `BPSW_WK_DEEP_MASK : `BPSW_WK_OFF_MASK;
        endcase
        return |(src & mask);
    endfunction : wake_ok

    function automatic logic [7:0] duty_of(input logic [7:0] t);
        logic [7:0] d;
        logic [10:0] ramp;
        d = 8'h00;
        ramp = {3'h0, 8'(t - `BPSW_FAN_T_ON)} << `BPSW_FAN_SLOPE;
        if (t >= `BPSW_FAN_T_FULL)
        begin
            d = `BPSW_FAN_FULL;
        end
        else if (t >= `BPSW_FAN_T_ON)
        begin
            d = (ramp > 11'h0FF) ? `BPSW_FAN_FULL : ramp[7:0];
        end
        return d;
    endfunction : duty_of

    localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);
    localparam logic [31:0] DEB_LAST = 32'(DEBOUNCE_CYCLES - 1);

    bpsw_state_t st_reg;
    bpsw_state_t st_next;
    logic press;
    logic [7:0] temp_max;

    assign press = ~pwr_sw_b;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.wake_pulse = 1'b0;
        // R05 enable is held clear through reset.
        st_next.lanpme_s5_en = lanpme_s5_en_in;

        // R12 debounce filter
        if (press == st_reg.sw_stable)
        begin
            st_next.db_cnt = '0;
        end
        else if (st_reg.db_cnt >= DEB_LAST)
        begin
            st_next.db_cnt = '0;
            st_next.sw_stable = press;
        end
        else
        begin
            st_next.db_cnt = st_reg.db_cnt + 32'h0000_0001;
        end

        if (st_reg.sw_stable)
        begin
            // R12 hold counter
            if (st_reg.hold_cnt != HOLD_LAST)
            begin
                st_next.hold_cnt = st_reg.hold_cnt + 32'h0000_0001;
            end
            else if (!st_reg.long_done)
            begin
                st_next.long_done = 1'b1;
                // R02 fail-safe off wins over sleep and wake
                if (st_reg.pstate != PS_S5)
                begin
                    st_next.pstate = PS_S5;
                end
            end
            if (st_next.sw_stable == 1'b0)
            begin
                st_next.hold_cnt = '0;
                st_next.long_done = 1'b0;
                // R01 short press acts on release
                if (!st_reg.long_done && st_reg.hold_cnt != HOLD_LAST)
                begin
                    unique case (st_reg.pstate)
                        PS_WORK: st_next.pstate =
                            sleep_to_disk ? PS_S4 : PS_S3;
                        PS_S3, PS_S4, PS_S5:
                        begin
                            st_next.pstate = PS_WORK;
                            st_next.wake_pulse = 1'b1;
                        end
                    endcase
                end
            end
        end
        // R03 R04 R05 wake source gating
        else if (wake_ok(st_reg.pstate, wake_src, st_reg.lanpme_s5_en))
        begin
            st_next.pstate = PS_WORK;
            st_next.wake_pulse = 1'b1;
        end

        // R06 core power only while working
        st_next.core_pwr_en = (st_next.pstate == PS_WORK);

        // R07 sticky intrusion; a new event wins over the clear
        if (chassis_closed)
        begin
            st_next.intrusion = 1'b1;
        end
        else if (intrusion_clr)
        begin
            st_next.intrusion = 1'b0;
        end

        // R08 window compare
        for (int i = 0; i < `BPSW_NUM_VOLT; i++)
        begin
            st_next.volt_fault[i] =
                (volt_in[i] > volt_hi[i]) || (volt_in[i] < volt_lo[i]);
        end

        // R10 hottest of the four sensors
        temp_max = temp_in[0];
        for (int i = 1; i < `BPSW_NUM_TEMP; i++)
        begin
            if (temp_in[i] > temp_max)
            begin
                temp_max = temp_in[i];
            end
        end

        // R09 R11 processor fan follows its own sensor, chassis fans the max
        for (int i = 0; i < `BPSW_NUM_FAN; i++)
        begin
            st_next.fan_duty[i] = (st_next.pstate != PS_WORK) ? 8'h00 :
                duty_of((i == 0) ? temp_in[0] : temp_max);
            st_next.fan_on[i] = (st_next.fan_duty[i] != 8'h00);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Soft-off at power-on; the supply waits for a press or wake.
            st_reg <= '{pstate: PS_S5, default: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign power_state = st_reg.pstate;
    assign core_pwr_en = st_reg.core_pwr_en;
    assign wake_pulse = st_reg.wake_pulse;
    assign intrusion = st_reg.intrusion;
    assign volt_fault = st_reg.volt_fault;
    assign fan_on = st_reg.fan_on;
    assign fan_duty = st_reg.fan_duty;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_short_press_on: assert property ( // R01
        @(posedge mclk) disable iff (!rst_b)
        st_reg.sw_stable && !st_next.sw_stable && !st_reg.long_done &&
        st_reg.pstate == PS_S5 && st_reg.hold_cnt != HOLD_LAST
        |=> st_reg.pstate == PS_WORK && st_reg.wake_pulse)
        else $error("Short press did not power on from soft-off.");

    a_long_press_off: assert property ( // R02
        @(posedge mclk) disable iff (!rst_b)
        st_reg.sw_stable && st_reg.hold_cnt == HOLD_LAST &&
        !st_reg.long_done
        |=> st_reg.pstate == PS_S5 ##1 st_reg.pstate == PS_S5)
        else $error("Long press did not force soft-off.");

    a_s3_wake_usb: assert property ( // R03
        @(posedge mclk) disable iff (!rst_b)
        st_reg.pstate == PS_S3 && !st_reg.sw_stable &&
        wake_src[`BPSW_WK_USB]
        |=> st_reg.pstate == PS_WORK ##1 st_reg.core_pwr_en)
        else $error("USB wake from suspend-to-RAM was lost.");

    a_deep_ignore: assert property ( // R04
        @(posedge mclk) disable iff (!rst_b)
        (st_reg.pstate == PS_S4 || st_reg.pstate == PS_S5) &&
        !st_reg.sw_stable && (wake_src & `BPSW_WK_DEEP_MASK) == 7'h00
        |=> $stable(st_reg.pstate))
        else $error("Ignored wake source woke a deep state.");

    a_lan_s5_gate: assert property ( // R05
        @(posedge mclk) disable iff (!rst_b)
        st_reg.pstate == PS_S5 && !st_reg.sw_stable &&
        !st_reg.lanpme_s5_en &&
        (wake_src & `BPSW_WK_OFF_MASK) == 7'h00
        |=> st_reg.pstate == PS_S5)
        else $error("Network wake from soft-off while disabled.");

    a_core_power: assert property ( // R06
        @(posedge mclk) disable iff (!rst_b)
        $changed(st_reg.pstate) |->
        st_reg.core_pwr_en == (st_reg.pstate == PS_WORK))
        else $error("Core power does not match the power state.");

    a_intrusion_set: assert property ( // R07
        @(posedge mclk) disable iff (!rst_b)
        chassis_closed |=> st_reg.intrusion)
        else $error("Intrusion was not reported.");

    a_volt_high: assert property ( // R08
        @(posedge mclk) disable iff (!rst_b)
        volt_in[4] > volt_hi[4] |=> st_reg.volt_fault[4])
        else $error("Over-limit voltage was not flagged.");

    a_fan_full: assert property ( // R09
        @(posedge mclk) disable iff (!rst_b)
        st_next.pstate == PS_WORK && temp_in[3] >= `BPSW_FAN_T_FULL
        |=> st_reg.fan_duty[2] == `BPSW_FAN_FULL && st_reg.fan_on[2])
        else $error("Chassis fan not at full on a hot sensor.");

    a_fan_off_sleep: assert property ( // R11
        @(posedge mclk) disable iff (!rst_b)
        st_reg.pstate != PS_WORK |-> st_reg.fan_on == 3'h0)
        else $error("Fan running outside the working state.");

    a_debounce_hold: assert property ( // R12
        @(posedge mclk) disable iff (!rst_b)
        press != st_reg.sw_stable && st_reg.db_cnt == 32'h0000_0000 &&
        DEBOUNCE_CYCLES > 1
        |=> $stable(st_reg.sw_stable))
        else $error("Switch level accepted without debounce.");

endmodule : bpsw_seq
`default_nettype wire
